// ===== verilog/gtl_defs.svh
`ifndef GTL_DEFS_SVH
`define GTL_DEFS_SVH

// ==========================================================
// register byte offsets
`define GTL_OFF_CTRL 5'h00
`define GTL_OFF_ADDR 5'h04
`define GTL_OFF_TXD 5'h08
`define GTL_OFF_RXD 5'h0c
`define GTL_OFF_STAT 5'h10

// ==========================================================
// field positions
`define GTL_CTRL_MODE_HI 1
`define GTL_CTRL_LF 2
`define GTL_CTRL_DBG 3
`define GTL_TXD_END 8

// ==========================================================
// reset values and limits
`define GTL_MODE_RST 2'h1
`define GTL_ADDR_RST 5'h01
`define GTL_LF_RST 1'b0
`define GTL_DBG_RST 1'b0
`define GTL_ADDR_MAX 8'h1e
`define GTL_MODE_BAD 2'h3

// ==========================================================
// bus characters and command groups
`define GTL_CH_LF 8'h0a
`define GTL_CH_CR 8'h0d
`define GTL_CMD_UNL 7'h3f
`define GTL_GRP_LISTEN 2'h1
`define GTL_GRP_TALK 2'h2

`endif

// ===== verilog/gtl_pkg.sv
package gtl_pkg;

    // ==========================================================
    // modes and handshake states
    typedef enum logic [1:0] {
        GTL_DET = 2'b00,
        GTL_TL = 2'b01,
        GTL_TO = 2'b10
    } gtl_mode_t;

    typedef enum logic [1:0] {
        GTL_A_IDLE = 2'b00,
        GTL_A_RDY = 2'b01,
        GTL_A_ACC = 2'b10
    } gtl_acc_t;

    typedef enum logic [1:0] {
        GTL_S_IDLE = 2'b00,
        GTL_S_SET = 2'b01,
        GTL_S_DAV = 2'b10,
        GTL_S_REL = 2'b11
    } gtl_src_t;

    // ==========================================================
    // state of the port apart from the transmit queue
    typedef struct packed {
        gtl_mode_t mode;
        logic [4:0] addr;
        logic lf;
        logic dbg;
        logic listen;
        logic talk;
        gtl_acc_t acc;
        gtl_src_t src;
        logic [1:0] seq;
        logic [7:0] rx_byte;
        logic rx_end;
        logic rx_full;
        logic [7:0] echo;
        logic echo_stb;
        logic wtr;
        logic [31:0] rdata;
        logic [7:0] dio_o;
        logic dio_oe_n;
        logic dav_oe_n;
        logic nrfd_oe_n;
        logic ndac_oe_n;
        logic eoi_oe_n;
        logic led_srq;
        logic led_nrfd;
        logic led_ndac;
    } gtl_state_t;

endpackage : gtl_pkg

// ===== verilog/gtl_buf2.sv
`timescale 1ns/1ps

module gtl_buf2 #(
    parameter int W = 9,
    parameter int D = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } gtl_buf_t;

    gtl_buf_t b_q;
    gtl_buf_t b_d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : nxt

    assign in_ready = (b_q.cnt != (AW + 1)'(D));
    assign out_valid = (b_q.cnt != '0);
    assign out_data = b_q.mem[b_q.rp];

    always_comb begin
        b_d = b_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            b_d.mem[b_q.wp] = in_data;
            b_d.wp = nxt(b_q.wp);
        end
        if (pop) begin
            b_d.rp = nxt(b_q.rp);
        end
        b_d.cnt = (AW + 1)'(b_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

endmodule : gtl_buf2

// ===== verilog/gtl_port.sv
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "gtl_defs.svh"

// Overview of operation
// - three modes only: talk/listen, transmit-only, detached; code 3 ignored
// - detached mode releases every bus line and ignores all traffic
// - controller messages handled only in talk/listen mode
// - transmit-only mode sends queued bytes with no controller involved
// - bus address writable 0 to 30; writes whose low byte is above 30 are ignored
// - last byte of every message goes out with EOI asserted
// - received byte with EOI marks end of incoming message
// - line-feed option also ends incoming message on a received LF
// - line-feed option ends output with CR, then LF carrying EOI
// - EOI-only option never treats LF as message end
// - debug on echoes each received data byte, not ATN commands; off after reset
// - SRQ lamp follows the SRQ line from any device
// - NRFD lamp lit while some listener is not ready
// - NDAC lamp lit while a byte sits unaccepted on the bus
module gtl_port #(
    parameter int TXBUF_DEPTH = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] dio_i,
    output logic [7:0] dio_o,
    output logic dio_oe_n,
    input wire logic dav_i,
    output logic dav_oe_n,
    input wire logic nrfd_i,
    output logic nrfd_oe_n,
    input wire logic ndac_i,
    output logic ndac_oe_n,
    input wire logic eoi_i,
    output logic eoi_oe_n,
    input wire logic atn_i,
    input wire logic srq_i,
    output logic led_srq,
    output logic led_nrfd,
    output logic led_ndac,
    output logic [7:0] echo_data,
    output logic echo_stb
);

    gtl_pkg::gtl_state_t s_q;
    gtl_pkg::gtl_state_t s_d;
    logic tx_in_valid;
    logic tx_in_ready;
    logic tx_out_valid;
    logic tx_out_ready;
    logic [8:0] tx_out_data;
    logic [8:0] pick;
    logic cap_dat;
    logic acc_en;
    logic src_en;

    // ==========================================================
    // byte to send for a queued word at a given trailer step
    function automatic logic [8:0] tx_pick(
        input logic [8:0] w,
        input logic [1:0] seq,
        input logic lf
    );
        logic [8:0] r;
        r = {1'b0, w[7:0]};
        if (w[`GTL_TXD_END] && !lf) begin
            r = {1'b1, w[7:0]};
        end else if (w[`GTL_TXD_END] && seq == 2'h1) begin
            r = {1'b0, `GTL_CH_CR};
        end else if (w[`GTL_TXD_END] && seq == 2'h2) begin
            r = {1'b1, `GTL_CH_LF};
        end
        return r;
    endfunction : tx_pick

    // ==========================================================
    // transmit queue; full queue stalls the bus write
    gtl_buf2 #(
        .W(9),
        .D(TXBUF_DEPTH)
    ) u_txbuf (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .in_data(avs_writedata[8:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data)
    );

    always_comb begin
        s_d = s_q;
        s_d.wtr = 1'b1;
        s_d.echo_stb = 1'b0;
        tx_in_valid = 1'b0;
        tx_out_ready = 1'b0;
        cap_dat = 1'b0;

        // ======================================================
        // register bus
        if ((avs_read || avs_write) && s_q.wtr) begin
            if (!(avs_write && avs_address == `GTL_OFF_TXD
                    && !tx_in_ready)) begin
                s_d.wtr = 1'b0;
                s_d.rdata = 32'h0000_0000;
                if (avs_write && avs_byteenable[0]) begin
                    case (avs_address)
                        `GTL_OFF_CTRL: begin
                            if (avs_writedata[1:0] != `GTL_MODE_BAD) begin
                                s_d.mode = gtl_pkg::gtl_mode_t'(
                                    avs_writedata[`GTL_CTRL_MODE_HI:0]);
                            end
                            s_d.lf = avs_writedata[`GTL_CTRL_LF];
                            s_d.dbg = avs_writedata[`GTL_CTRL_DBG];
                        end
                        `GTL_OFF_ADDR: begin
                            if (avs_writedata[7:0] <= `GTL_ADDR_MAX) begin
                                s_d.addr = avs_writedata[4:0];
                            end
                        end
                        `GTL_OFF_TXD: begin
                            tx_in_valid = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
                if (avs_read) begin
                    case (avs_address)
                        `GTL_OFF_CTRL: begin
                            s_d.rdata = {28'h0, s_q.dbg, s_q.lf, s_q.mode};
                        end
                        `GTL_OFF_ADDR: begin
                            s_d.rdata = {27'h0, s_q.addr};
                        end
                        `GTL_OFF_RXD: begin
                            s_d.rdata = {s_q.rx_full, 22'h0, s_q.rx_end,
                                s_q.rx_byte};
                            s_d.rx_full = 1'b0;
                        end
                        `GTL_OFF_STAT: begin
                            s_d.rdata = {20'h0, s_q.src, s_q.acc, s_q.talk,
                                s_q.listen, s_q.led_ndac, s_q.led_nrfd,
                                s_q.led_srq, !tx_in_ready, tx_out_valid,
                                s_q.rx_full};
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // addressed states exist only in talk/listen mode
        if (s_d.mode != gtl_pkg::GTL_TL) begin
            s_d.listen = 1'b0;
            s_d.talk = 1'b0;
        end

        // ======================================================
        // front-panel lamps
        s_d.led_srq = srq_i;
        s_d.led_nrfd = nrfd_i;
        s_d.led_ndac = ndac_i && dav_i;

        // ======================================================
        // acceptor: commands under ATN, data while listening
        acc_en = (s_d.mode == gtl_pkg::GTL_TL)
            && (atn_i || s_q.listen);
        if (!acc_en) begin
            s_d.acc = gtl_pkg::GTL_A_IDLE;
            s_d.nrfd_oe_n = 1'b1;
            s_d.ndac_oe_n = 1'b1;
        end else begin
            case (s_q.acc)
                gtl_pkg::GTL_A_IDLE: begin
                    s_d.nrfd_oe_n = 1'b0;
                    s_d.ndac_oe_n = 1'b0;
                    s_d.acc = gtl_pkg::GTL_A_RDY;
                end
                gtl_pkg::GTL_A_RDY: begin
                    // not ready while an unread byte is held, unless ATN is asserted
                    s_d.nrfd_oe_n = atn_i || !s_q.rx_full;
                    if (dav_i && s_q.nrfd_oe_n
                            && (atn_i || !s_q.rx_full)) begin
                        s_d.nrfd_oe_n = 1'b0;
                        s_d.ndac_oe_n = 1'b1;
                        s_d.acc = gtl_pkg::GTL_A_ACC;
                        if (atn_i) begin
                            if (dio_i[6:5] == `GTL_GRP_LISTEN) begin
                                if (dio_i[6:0] == `GTL_CMD_UNL) begin
                                    s_d.listen = 1'b0;
                                end else if (dio_i[4:0] == s_q.addr) begin
                                    s_d.listen = 1'b1;
                                    s_d.talk = 1'b0;
                                end
                            end else if (dio_i[6:5] == `GTL_GRP_TALK) begin
                                s_d.talk = (dio_i[4:0] == s_q.addr);
                                if (dio_i[4:0] == s_q.addr) begin
                                    s_d.listen = 1'b0;
                                end
                            end
                        end else begin
                            cap_dat = 1'b1;
                            s_d.rx_byte = dio_i;
                            s_d.rx_end = eoi_i
                                || (s_q.lf && dio_i == `GTL_CH_LF);
                            s_d.rx_full = 1'b1;
                            if (s_q.dbg) begin
                                s_d.echo = dio_i;
                                s_d.echo_stb = 1'b1;
                            end
                        end
                    end
                end
                gtl_pkg::GTL_A_ACC: begin
                    if (!dav_i) begin
                        s_d.ndac_oe_n = 1'b0;
                        s_d.acc = gtl_pkg::GTL_A_RDY;
                    end
                end
                default: begin
                    s_d.acc = gtl_pkg::GTL_A_IDLE;
                end
            endcase
        end

        // ======================================================
        // source: talk-only needs no controller
        src_en = (s_d.mode == gtl_pkg::GTL_TO)
            || (s_d.mode == gtl_pkg::GTL_TL && s_q.talk && !atn_i);
        pick = tx_pick(tx_out_data, s_q.seq, s_q.lf);
        if (!src_en) begin
            s_d.src = gtl_pkg::GTL_S_IDLE;
            s_d.seq = 2'h0;
            s_d.dio_oe_n = 1'b1;
            s_d.dav_oe_n = 1'b1;
            s_d.eoi_oe_n = 1'b1;
        end else begin
            case (s_q.src)
                gtl_pkg::GTL_S_IDLE: begin
                    if (tx_out_valid) begin
                        s_d.dio_o = pick[7:0];
                        s_d.dio_oe_n = 1'b0;
                        s_d.eoi_oe_n = !pick[8];
                        s_d.src = gtl_pkg::GTL_S_SET;
                    end
                end
                gtl_pkg::GTL_S_SET: begin
                    // data settled one cycle; wait for all listeners
                    if (!nrfd_i && ndac_i) begin
                        s_d.dav_oe_n = 1'b0;
                        s_d.src = gtl_pkg::GTL_S_DAV;
                    end
                end
                gtl_pkg::GTL_S_DAV: begin
                    if (!ndac_i) begin
                        s_d.dav_oe_n = 1'b1;
                        s_d.src = gtl_pkg::GTL_S_REL;
                    end
                end
                gtl_pkg::GTL_S_REL: begin
                    s_d.dio_oe_n = 1'b1;
                    s_d.eoi_oe_n = 1'b1;
                    s_d.src = gtl_pkg::GTL_S_IDLE;
                    if (tx_out_data[`GTL_TXD_END] && s_q.lf
                            && s_q.seq != 2'h2) begin
                        s_d.seq = 2'(s_q.seq + 2'h1);
                    end else begin
                        s_d.seq = 2'h0;
                        tx_out_ready = 1'b1;
                    end
                end
                default: begin
                    s_d.src = gtl_pkg::GTL_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.mode <= gtl_pkg::gtl_mode_t'(`GTL_MODE_RST);
            s_q.addr <= `GTL_ADDR_RST;
            s_q.lf <= `GTL_LF_RST;
            s_q.dbg <= `GTL_DBG_RST;
            s_q.wtr <= 1'b1;
            s_q.dio_oe_n <= 1'b1;
            s_q.dav_oe_n <= 1'b1;
            s_q.nrfd_oe_n <= 1'b1;
            s_q.ndac_oe_n <= 1'b1;
            s_q.eoi_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wtr;
    assign dio_o = s_q.dio_o;
    assign dio_oe_n = s_q.dio_oe_n;
    assign dav_oe_n = s_q.dav_oe_n;
    assign nrfd_oe_n = s_q.nrfd_oe_n;
    assign ndac_oe_n = s_q.ndac_oe_n;
    assign eoi_oe_n = s_q.eoi_oe_n;
    assign led_srq = s_q.led_srq;
    assign led_nrfd = s_q.led_nrfd;
    assign led_ndac = s_q.led_ndac;
    assign echo_data = s_q.echo;
    assign echo_stb = s_q.echo_stb;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence src_armed;
        s_q.src == gtl_pkg::GTL_S_SET && src_en;
    endsequence

    sequence lsn_ready;
        !nrfd_i && ndac_i;
    endsequence

    mode_legal_a: assert property (s_q.mode != `GTL_MODE_BAD)
        else $error("illegal bus mode code");

    detach_quiet_a: assert property (
        s_q.mode == gtl_pkg::GTL_DET |-> s_q.dio_oe_n && s_q.dav_oe_n
            && s_q.nrfd_oe_n && s_q.ndac_oe_n && s_q.eoi_oe_n)
        else $error("detached port drives a bus line");

    addressed_tl_a: assert property (
        (s_q.listen || s_q.talk) |-> s_q.mode == gtl_pkg::GTL_TL)
        else $error("addressed outside talk/listen mode");

    talk_only_a: assert property (
        s_q.mode == gtl_pkg::GTL_TO && s_q.src == gtl_pkg::GTL_S_IDLE
            && tx_out_valid
        |=> s_q.mode != gtl_pkg::GTL_TO || !s_q.dio_oe_n)
        else $error("talk-only byte not driven");

    addr_range_a: assert property (
        {3'h0, s_q.addr} <= `GTL_ADDR_MAX)
        else $error("bus address above 30");

    eoi_last_a: assert property (
        tx_out_ready && tx_out_data[`GTL_TXD_END] |-> !s_q.eoi_oe_n)
        else $error("final byte sent without EOI");

    eoi_end_a: assert property (
        cap_dat && eoi_i |=> s_q.rx_end && s_q.rx_full)
        else $error("EOI byte not marked as end");

    lf_end_a: assert property (
        cap_dat && s_q.lf && dio_i == `GTL_CH_LF |=> s_q.rx_end)
        else $error("LF not taken as end");

    crlf_tail_a: assert property (
        s_q.lf && !s_q.eoi_oe_n |-> s_q.dio_o == `GTL_CH_LF)
        else $error("EOI without LF in LF mode");

    eoi_only_a: assert property (
        cap_dat && !s_q.lf && !eoi_i |=> !s_q.rx_end)
        else $error("end seen without EOI");

    debug_echo_a: assert property (
        cap_dat && s_q.dbg |=> s_q.echo_stb && s_q.echo == $past(dio_i))
        else $error("debug echo missing");

    srq_lamp_a: assert property (srq_i |=> s_q.led_srq)
        else $error("SRQ lamp dark");

    nrfd_lamp_a: assert property (nrfd_i |=> s_q.led_nrfd)
        else $error("NRFD lamp dark");

    ndac_lamp_a: assert property (
        dav_i && ndac_i |=> s_q.led_ndac)
        else $error("NDAC lamp dark");

    dav_gate_a: assert property (
        src_armed and lsn_ready |=> !s_q.dav_oe_n && !s_q.dio_oe_n)
        else $error("DAV not raised for ready listeners");

endmodule : gtl_port

// ===== testbench/gtl_ctl_model.sv
`timescale 1ns/1ps

// ==========
// controller and listen-always printer on the far side
module gtl_ctl_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] dio_o,
    input wire logic dio_oe_n,
    input wire logic dav_oe_n,
    input wire logic nrfd_oe_n,
    input wire logic ndac_oe_n,
    input wire logic eoi_oe_n,
    input wire logic [3:0] slow,
    output logic [7:0] dio_i,
    output logic dav_i,
    output logic nrfd_i,
    output logic ndac_i,
    output logic eoi_i,
    output logic atn_i
);
    logic s_on = 1'b0;
    logic s_dav = 1'b0;
    logic s_eoi = 1'b0;
    logic s_atn = 1'b0;
    logic [7:0] s_dio = 8'h00;
    logic a_nrfd, a_ndac, a_got;
    logic [3:0] a_cnt;
    logic [8:0] rx_q[$];
    // wired-or lines, released lines pulled to idle
    assign dio_i = (dio_oe_n ? 8'h00 : dio_o) | s_dio;
    assign dav_i = !dav_oe_n | s_dav;
    assign nrfd_i = !nrfd_oe_n | (a_nrfd & !s_on);
    assign ndac_i = !ndac_oe_n | (a_ndac & !s_on);
    assign eoi_i = !eoi_oe_n | s_eoi;
    assign atn_i = s_atn;
    // listens always, no own address needed
    always @(posedge mclk) begin
        if (sys_rst) begin
            a_nrfd <= 1'b0;
            a_ndac <= 1'b1;
            a_got <= 1'b0;
            a_cnt <= 4'h0;
        end else if (!s_on) begin
            if (dav_i && !a_got) begin
                rx_q.push_back({eoi_i, dio_i});
                a_got <= 1'b1;
                a_nrfd <= 1'b1;
                a_ndac <= 1'b0;
            end else if (!dav_i && a_got) begin
                a_got <= 1'b0;
                a_ndac <= 1'b1;
                a_cnt <= slow;
            end else if (a_cnt != 4'h0) begin
                a_cnt <= a_cnt - 4'h1;
            end else if (!a_got) begin
                a_nrfd <= 1'b0;
            end
        end
    end
    task send(input logic [7:0] b, input logic e, a, output logic ok);
        int n;
        @(posedge mclk);
        s_on <= 1'b1;
        s_dio <= b;
        s_eoi <= e;
        s_atn <= a;
        n = 0;
        @(posedge mclk);
        while (!(nrfd_i === 1'b0 && ndac_i === 1'b1) && n < 40) begin
            @(posedge mclk);
            n++;
        end
        ok = n < 40;
        if (ok) begin
            s_dav <= 1'b1;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (ndac_i !== 1'b0 && n < 40);
        end
        s_dav <= 1'b0;
        @(posedge mclk);
        s_on <= 1'b0;
        s_dio <= 8'h00;
        s_eoi <= 1'b0;
        s_atn <= 1'b0;
    endtask : send
endmodule : gtl_ctl_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
`include "gtl_defs.svh"

// ==========
// bench top
module tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] dio_i, dio_o, echo_data;
    logic dio_oe_n, dav_i, dav_oe_n, nrfd_i, nrfd_oe_n, ndac_i, ndac_oe_n;
    logic eoi_i, eoi_oe_n, atn_i, led_srq, led_nrfd, led_ndac, echo_stb;
    logic srq = 1'b0;
    logic [3:0] slow = 4'h0;
    logic rst_d, l_s, l_r, l_a, ok, lf, dbg;
    logic [31:0] rnd = 32'h16d3a716;
    logic [4:0] a;
    logic [8:0] exp_q[$];
    logic [7:0] echo_q[$];
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int m;

    gtl_port #(.TXBUF_DEPTH(2)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dio_i(dio_i), .dio_o(dio_o),
        .dio_oe_n(dio_oe_n), .dav_i(dav_i), .dav_oe_n(dav_oe_n),
        .nrfd_i(nrfd_i), .nrfd_oe_n(nrfd_oe_n), .ndac_i(ndac_i),
        .ndac_oe_n(ndac_oe_n), .eoi_i(eoi_i), .eoi_oe_n(eoi_oe_n),
        .atn_i(atn_i), .srq_i(srq), .led_srq(led_srq),
        .led_nrfd(led_nrfd), .led_ndac(led_ndac),
        .echo_data(echo_data), .echo_stb(echo_stb));
    gtl_ctl_model i_ctl (.mclk(mclk), .sys_rst(sys_rst), .dio_o(dio_o),
        .dio_oe_n(dio_oe_n), .dav_oe_n(dav_oe_n), .nrfd_oe_n(nrfd_oe_n),
        .ndac_oe_n(ndac_oe_n), .eoi_oe_n(eoi_oe_n), .slow(slow),
        .dio_i(dio_i), .dav_i(dav_i), .nrfd_i(nrfd_i), .ndac_i(ndac_i),
        .eoi_i(eoi_i), .atn_i(atn_i));

    initial begin
        forever #10 mclk = !mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    task chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    task test_done;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task bus(input logic [4:0] ad, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task wr(input logic [4:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(ad, 1'b1, d, q);
    endtask : wr

    task rd(input logic [4:0] ad, input logic [31:0] mk, e);
        logic [31:0] q;
        bus(ad, 1'b0, 32'h0, q);
        chk($sformatf("reg %h", ad), q & mk, e);
    endtask : rd

    task rxb(input logic [7:0] b, input logic e);
        logic [31:0] q;
        i_ctl.send(b, e, 1'b0, ok);
        chk("rx taken", ok, 1'b1);
        bus(`GTL_OFF_RXD, 1'b0, 32'h0, q);
        chk("rxd", q, {1'b1, 22'h0, e | (lf && b == `GTL_CH_LF), b});
        if (dbg) chk("echo", echo_q[echo_q.size() - 1], b);
    endtask : rxb

    task txmsg(input int n);
        logic [7:0] b;
        int k;
        for (k = 0; k < n; k++) begin
            rnd = lfsr(rnd);
            b = rnd[7:0];
            wr(`GTL_OFF_TXD, {23'h0, k == n - 1, b});
            exp_q.push_back({k == n - 1 && !lf, b});
        end
        if (lf) begin
            exp_q.push_back({1'b0, `GTL_CH_CR});
            exp_q.push_back({1'b1, `GTL_CH_LF});
        end
        for (k = 0; k < 500 && i_ctl.rx_q.size() < exp_q.size(); k++)
            @(posedge mclk);
        chk("tx count", i_ctl.rx_q.size(), exp_q.size());
        while (exp_q.size() > 0 && i_ctl.rx_q.size() > 0)
            chk("tx word", i_ctl.rx_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
    endtask : txmsg

    // ==========
    // lamps one cycle behind the lines, timeout, echo capture
    always @(posedge mclk) begin
        cyc++;
        srq <= rnd[5] ^ cyc[6];
        if (echo_stb === 1'b1) echo_q.push_back(echo_data);
        if (!sys_rst && !rst_d) begin
            chk("led srq", led_srq, l_s);
            chk("led nrfd", led_nrfd, l_r);
            chk("led ndac", led_ndac, l_a);
        end
        rst_d <= sys_rst;
        l_s <= srq;
        l_r <= nrfd_i;
        l_a <= ndac_i & dav_i;
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(`GTL_OFF_CTRL, 32'hf, 32'h1);
        rd(`GTL_OFF_ADDR, 32'h1f, 32'h1);
        rd(5'h14, 32'hffffffff, 32'h0);
        for (m = 0; m < 4; m++) begin
            wr(`GTL_OFF_CTRL, 32'(m));
            rd(`GTL_OFF_CTRL, 32'h3, m == 3 ? 32'h2 : 32'(m));
        end
        wr(`GTL_OFF_ADDR, 32'd30);
        wr(`GTL_OFF_ADDR, 32'd31);
        wr(`GTL_OFF_ADDR, 32'h21);
        rd(`GTL_OFF_ADDR, 32'h1f, 32'd30);
        rnd = lfsr(rnd);
        a = 5'(rnd % 31);
        wr(`GTL_OFF_ADDR, {27'h0, a});
        rd(`GTL_OFF_ADDR, 32'h1f, {27'h0, a});
        wr(`GTL_OFF_CTRL, 32'h1);
        i_ctl.send({3'h1, a}, 1'b0, 1'b1, ok);
        chk("listen", ok, 1'b1);
        for (m = 0; m < 3; m++) begin
            lf = m == 2;
            dbg = m != 0;
            wr(`GTL_OFF_CTRL, {28'h0, dbg, lf, 2'h1});
            echo_q.delete();
            rxb(`GTL_CH_LF, 1'b0);
            rnd = lfsr(rnd);
            rxb(rnd[7:0], rnd[8]);
            chk("echo n", echo_q.size(), dbg ? 2 : 0);
        end
        i_ctl.send({3'h2, a}, 1'b0, 1'b1, ok);
        chk("talk", ok, 1'b1);
        for (m = 0; m < 2; m++) begin
            lf = m == 1;
            slow = lf ? 4'h5 : 4'h0;
            wr(`GTL_OFF_CTRL, {29'h0, lf, 2'h1});
            txmsg(3);
        end
        lf = 1'b0;
        wr(`GTL_OFF_CTRL, 32'h2);
        txmsg(2);
        wr(`GTL_OFF_CTRL, 32'h0);
        i_ctl.send(8'h55, 1'b1, 1'b0, ok);
        chk("detached", ok, 1'b0);
        chk("dio released", dio_oe_n, 1'b1);
        rd(`GTL_OFF_STAT, 32'h1, 32'h0);
        test_done;
    end
endmodule : tb
